// ===== flbf_pkg.sv
// Behaviour
// [R1] Bytes 48..71: per channel status-vout, status-mfr, low byte of second status word.
// [R2] Block opens with a 72-byte preamble, bytes 0..71, before any cyclic byte.
// [R3] Byte 72 is the loop entry at the stored last-position pointer.
// [R4] Cyclic data fills bytes 72..237; bytes 238..254 are reserved.
// [R5] Byte 72 entry has position equal to last-position; reader decodes with it.
// [R6] Each later cyclic byte comes from the position one lower, newest first.
// [R7] A loop is 46 bytes; 166 cyclic bytes hold about 3.6 loops.
// [R8] Loop layout: per channel volts low, high, three statuses; vin at 10, temp at 23.
// [R9] Bus data bytes count from 1; table byte 0 follows the byte count.
// [R10] Byte count field is 0xFF, followed first by the last-position pointer.
// [R11] Below position 0 the walk wraps to position 45 until byte 237.
// [R12] A read returns the whole 255-byte block copied from the log buffer.
// [R13] Log buffer refreshes each conversion while unlocked; locked stays until next read. The code drops conversions that arrive during a read.
// [R14] Preamble byte 1 is the valid cyclic byte count; 0xFF means all valid.
package flbf_pkg;
  localparam int FLBF_CHANNELS = 8;
  localparam int FLBF_PREAMBLE_LEN = 72;
  localparam int FLBF_CYCLIC_LAST = 237;
  localparam int FLBF_BLOCK_LEN = 255;
  localparam int FLBF_LOOP_LEN = 46;
  localparam int FLBF_HIST_LEN = FLBF_CYCLIC_LAST + 1 - FLBF_PREAMBLE_LEN;
  localparam int FLBF_FIFO_DEPTH = 4;
  localparam int FLBF_FIFO_WIDTH = 9;
  // Preamble byte offsets
  localparam int FLBF_OFS_POS_LAST = 0;
  localparam int FLBF_OFS_VALID_COUNT = 1;
  localparam int FLBF_OFS_TIME = 2;
  localparam int FLBF_OFS_PEAK_MIN = 8;
  localparam int FLBF_PEAK_MIN_GROUP = 4;
  localparam int FLBF_OFS_STATUS = 48;
  localparam int FLBF_STATUS_TRIPLE = 3;
  localparam int FLBF_TIME_BITS = 41;
  // Loop positions
  localparam int FLBF_CHAN_SLOT = 5;
  localparam int FLBF_POS_VIN = 10;
  localparam int FLBF_POS_CH2 = 13;
  localparam int FLBF_POS_TEMP = 23;
  localparam int FLBF_POS_CH4 = 26;
  localparam logic [7:0] FLBF_BYTE_COUNT = 8'hFF;
  localparam logic [7:0] FLBF_VALID_ALL = 8'hFF;
  localparam logic [7:0] FLBF_RESERVED_BYTE = 8'h00;

  typedef enum logic [2:0] {
    FLBF_ST_IDLE = 3'h1,
    FLBF_ST_SEND = 3'h2,
    FLBF_ST_FINISH = 3'h4
  } flbf_state_type;
endpackage : flbf_pkg

// ===== flbf_fifo.sv
module flbf_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_COUNT = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  assign in_ready_out = (count != FULL_COUNT);
  assign out_valid_out = (count != '0);
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_data_out = mem[rd_ptr];

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST_SLOT) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST_SLOT) ? '0 : rd_ptr + 1'b1;
      end
      case ({push, pop})
        2'b10: count <= count + 1'b1;
        2'b01: count <= count - 1'b1;
        default: count <= count;
      endcase
    end
  end
endmodule : flbf_fifo

// ===== flbf_formatter.sv
module flbf_formatter
  import flbf_pkg::*;
(
  input wire logic REF_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic CONV_DONE_IN,
  input wire logic LOCK_SET_IN,
  input wire logic READ_REQ_IN,
  input wire logic [7:0][15:0] CHAN_OUT_VOLT_IN,
  input wire logic [15:0] VIN_VOLT_IN,
  input wire logic [15:0] TEMP_IN,
  input wire logic [7:0][7:0] STATUS_VOUT_IN,
  input wire logic [7:0][7:0] STATUS_MFR_IN,
  input wire logic [7:0][15:0] STATUS_WORD2_IN,
  input wire logic [7:0] STATUS_VIN_IN,
  input wire logic [7:0] STATUS_TEMP_IN,
  input wire logic [7:0][15:0] CHAN_OUT_VOLT_PEAK_IN,
  input wire logic [7:0][15:0] CHAN_OUT_VOLT_MINIMUM_IN,
  input wire logic [15:0] VIN_PEAK_IN,
  input wire logic [15:0] VIN_MINIMUM_IN,
  input wire logic [15:0] TEMP_PEAK_IN,
  input wire logic [15:0] TEMP_MINIMUM_IN,
  input wire logic [40:0] SHARED_TIME_IN,
  input wire logic BLK_READY_IN,
  output logic BLK_VALID_OUT,
  output logic [7:0] BLK_DATA_OUT,
  output logic BLK_LAST_OUT,
  output logic READ_BUSY_OUT,
  output logic RAM_LOCKED_OUT
);
  localparam logic [7:0] HIST_TOP = 8'(FLBF_HIST_LEN - 1);
  localparam logic [7:0] HIST_FULL = 8'(FLBF_HIST_LEN);
  localparam logic [5:0] POS_TOP = 6'(FLBF_LOOP_LEN - 1);
  // Sequence counter wraps to zero on the last push, so eight bits suffice
  localparam logic [7:0] SEQ_LAST = 8'(FLBF_BLOCK_LEN);

  flbf_state_type state;
  logic locked;
  // Cyclic history and write side
  logic [7:0] hist [FLBF_HIST_LEN];
  logic [7:0] wr_idx;
  logic [5:0] wr_pos;
  logic [5:0] pos_last;
  logic [7:0] hist_count;
  logic [7:0] loop_byte;
  logic log_write;
  // Preamble snapshot
  logic [40:0] snap_time;
  logic [7:0][15:0] snap_peak;
  logic [7:0][15:0] snap_min;
  logic [15:0] snap_vin_peak;
  logic [15:0] snap_vin_min;
  logic [15:0] snap_temp_peak;
  logic [15:0] snap_temp_min;
  logic [7:0][7:0] snap_vout;
  logic [7:0][7:0] snap_mfr;
  logic [7:0][7:0] snap_st2;
  // Read side: seq 0 is the count field, seq 1..255 are table bytes 0..254
  logic [7:0] seq;
  logic [7:0] rd_idx;
  logic [7:0] push_byte;
  logic push_valid;
  logic push_ready;
  logic push_ok;
  logic [FLBF_FIFO_WIDTH-1:0] fifo_out;

  // Byte of a 16-bit word, low byte for sel 0
  function automatic logic [7:0] word_byte(input logic [15:0] w, input logic sel);
    word_byte = sel ? w[15:8] : w[7:0];
  endfunction : word_byte

  // Previous ring slot; one slot per cyclic byte, so no position math is needed
  function automatic logic [7:0] hist_prev(input logic [7:0] idx);
    hist_prev = (idx == 8'h00) ? HIST_TOP : idx - 8'h01;
  endfunction : hist_prev

  // Byte the loop holds at the current write position
  // One conversion fills one loop position, so the decode follows the write pointer
  always_comb begin
    int p;
    int ch;
    int k;
    p = int'(wr_pos);
    ch = 0;
    k = 0;
    loop_byte = 8'h00;
    if (p >= FLBF_POS_VIN && p < FLBF_POS_CH2) begin
      k = p - FLBF_POS_VIN;
      loop_byte = (k == 2) ? STATUS_VIN_IN : word_byte(VIN_VOLT_IN, k[0]); // R8
    end else if (p >= FLBF_POS_TEMP && p < FLBF_POS_CH4) begin
      k = p - FLBF_POS_TEMP;
      loop_byte = (k == 2) ? STATUS_TEMP_IN : word_byte(TEMP_IN, k[0]); // R8
    end else begin
      if (p < FLBF_POS_VIN) begin
        ch = p / FLBF_CHAN_SLOT;
        k = p % FLBF_CHAN_SLOT;
      end else if (p < FLBF_POS_TEMP) begin
        ch = 2 + (p - FLBF_POS_CH2) / FLBF_CHAN_SLOT;
        k = (p - FLBF_POS_CH2) % FLBF_CHAN_SLOT;
      end else begin
        ch = 4 + (p - FLBF_POS_CH4) / FLBF_CHAN_SLOT;
        k = (p - FLBF_POS_CH4) % FLBF_CHAN_SLOT;
      end
      case (k)
        0: loop_byte = CHAN_OUT_VOLT_IN[ch[2:0]][7:0]; // R8
        1: loop_byte = CHAN_OUT_VOLT_IN[ch[2:0]][15:8];
        2: loop_byte = STATUS_VOUT_IN[ch[2:0]];
        3: loop_byte = STATUS_MFR_IN[ch[2:0]];
        default: loop_byte = STATUS_WORD2_IN[ch[2:0]][7:0];
      endcase
    end
  end

  // Writes pause during a block read so the copy being sent stays coherent
  assign log_write = CONV_DONE_IN && !locked && (state == FLBF_ST_IDLE); // R13

  always_ff @(posedge REF_CLK_IN) begin
    if (log_write) begin
      hist[wr_idx] <= loop_byte;
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      wr_idx <= 8'h00;
      wr_pos <= 6'h00;
      pos_last <= 6'h00;
      hist_count <= 8'h00;
    end else if (log_write) begin
      wr_idx <= (wr_idx == HIST_TOP) ? 8'h00 : wr_idx + 8'h01;
      wr_pos <= (wr_pos == POS_TOP) ? 6'h00 : wr_pos + 6'h01; // R7
      // Tracks the byte just written, the newest entry of the loop
      pos_last <= wr_pos;
      // Saturates at a full ring so the valid marker stays steady
      if (hist_count != HIST_FULL) begin
        hist_count <= hist_count + 8'h01;
      end
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      // Cleared so a read before any conversion shows a zero preamble
      snap_time <= '0;
      snap_peak <= '0;
      snap_min <= '0;
      snap_vin_peak <= 16'h0000;
      snap_vin_min <= 16'h0000;
      snap_temp_peak <= 16'h0000;
      snap_temp_min <= 16'h0000;
      snap_vout <= '0;
      snap_mfr <= '0;
      snap_st2 <= '0;
    end else if (log_write) begin // R13
      snap_time <= SHARED_TIME_IN;
      snap_peak <= CHAN_OUT_VOLT_PEAK_IN;
      snap_min <= CHAN_OUT_VOLT_MINIMUM_IN;
      snap_vin_peak <= VIN_PEAK_IN;
      snap_vin_min <= VIN_MINIMUM_IN;
      snap_temp_peak <= TEMP_PEAK_IN;
      snap_temp_min <= TEMP_MINIMUM_IN;
      snap_vout <= STATUS_VOUT_IN;
      snap_mfr <= STATUS_MFR_IN;
      for (int c = 0; c < FLBF_CHANNELS; c++) begin
        snap_st2[c] <= STATUS_WORD2_IN[c][7:0]; // R1
      end
    end
  end

  // Lock: a fault freezes the log; a completed read releases it
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      locked <= 1'b0;
    end else if (LOCK_SET_IN) begin
      locked <= 1'b1;
    end else if (state == FLBF_ST_FINISH) begin
      locked <= 1'b0; // R13
    end
  end

  // Byte for the current sequence slot; slot 0 is the count field
  always_comb begin
    int b;
    int g;
    int w;
    int ch;
    logic [15:0] pk;
    logic [15:0] mn;
    b = int'(seq) - 1; // R9
    g = 0;
    w = 0;
    ch = 0;
    pk = 16'h0000;
    mn = 16'h0000;
    push_byte = FLBF_RESERVED_BYTE;
    if (seq == 8'h00) begin
      push_byte = FLBF_BYTE_COUNT; // R10
    end else if (b == FLBF_OFS_POS_LAST) begin
      push_byte = {2'b00, pos_last}; // R10
    end else if (b == FLBF_OFS_VALID_COUNT) begin
      push_byte = (hist_count == HIST_FULL) ? FLBF_VALID_ALL : hist_count; // R14
    end else if (b < FLBF_OFS_PEAK_MIN) begin
      // Byte 7 holds only the top time bit; its upper bits read as zero
      w = (b - FLBF_OFS_TIME) * 8;
      push_byte = 8'({7'h00, snap_time} >> w);
    end else if (b < FLBF_OFS_STATUS) begin
      g = (b - FLBF_OFS_PEAK_MIN) / FLBF_PEAK_MIN_GROUP;
      w = (b - FLBF_OFS_PEAK_MIN) % FLBF_PEAK_MIN_GROUP;
      if (g == 2) begin
        pk = snap_vin_peak;
        mn = snap_vin_min;
      end else if (g == 5) begin
        pk = snap_temp_peak;
        mn = snap_temp_min;
      end else begin
        ch = (g < 2) ? g : ((g < 5) ? g - 1 : g - 2);
        pk = snap_peak[ch[2:0]];
        mn = snap_min[ch[2:0]];
      end
      push_byte = word_byte((w < 2) ? pk : mn, w[0]);
    end else if (b < FLBF_PREAMBLE_LEN) begin // R2
      ch = (b - FLBF_OFS_STATUS) / FLBF_STATUS_TRIPLE;
      w = (b - FLBF_OFS_STATUS) % FLBF_STATUS_TRIPLE;
      case (w)
        0: push_byte = snap_vout[ch[2:0]]; // R1
        1: push_byte = snap_mfr[ch[2:0]];
        default: push_byte = snap_st2[ch[2:0]];
      endcase
    end else if (b <= FLBF_CYCLIC_LAST) begin // R4
      // Slots past the cyclic region keep the reserved default set above
      push_byte = hist[rd_idx]; // R3 R5
    end
  end

  // A full FIFO stalls the producer, so backpressure never drops a byte
  assign push_valid = (state == FLBF_ST_SEND);
  assign push_ok = push_valid && push_ready;

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state <= FLBF_ST_IDLE;
      seq <= 8'h00;
    end else begin
      case (state)
        FLBF_ST_IDLE: begin
          seq <= 8'h00;
          if (READ_REQ_IN) begin
            state <= FLBF_ST_SEND;
          end
        end
        FLBF_ST_SEND: begin
          if (push_ok) begin
            seq <= seq + 8'h01;
            if (seq == SEQ_LAST) begin
              state <= FLBF_ST_FINISH; // R12
            end
          end
        end
        // One cycle here releases the lock only after the last byte is queued
        FLBF_ST_FINISH: begin
          state <= FLBF_ST_IDLE;
        end
        default: begin
          state <= FLBF_ST_IDLE;
        end
      endcase
    end
  end

  // Walks back from the newest byte, one position lower per byte
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rd_idx <= 8'h00;
    end else if (state == FLBF_ST_IDLE) begin
      // A conversion taken on the request edge is the newest byte of this read
      if (log_write) begin
        rd_idx <= wr_idx; // R3
      end else begin
        rd_idx <= hist_prev(wr_idx); // R3
      end
    end else if (push_ok && int'(seq) > FLBF_PREAMBLE_LEN) begin
      rd_idx <= hist_prev(rd_idx); // R6 R11
    end
  end

  // Bit 8 of each FIFO word carries the end-of-block flag beside its byte
  flbf_fifo #(
    .WIDTH(FLBF_FIFO_WIDTH),
    .DEPTH(FLBF_FIFO_DEPTH)
  ) u_fifo (
    .clk_in(REF_CLK_IN),
    .resetn_in(RESETN_IN),
    .in_valid_in(push_valid),
    .in_ready_out(push_ready),
    .in_data_in({seq == SEQ_LAST, push_byte}),
    .out_valid_out(BLK_VALID_OUT),
    .out_ready_in(BLK_READY_IN),
    .out_data_out(fifo_out)
  );

  assign BLK_DATA_OUT = fifo_out[7:0];
  assign BLK_LAST_OUT = fifo_out[8];
  assign READ_BUSY_OUT = (state != FLBF_ST_IDLE);
  assign RAM_LOCKED_OUT = locked;
endmodule : flbf_formatter

// ===== flbf_checker.sv
module flbf_checker (
  input wire logic REF_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic READ_REQ_IN,
  input wire logic LOCK_SET_IN,
  input wire logic BLK_READY_IN,
  input wire logic BLK_VALID_OUT,
  input wire logic [7:0] BLK_DATA_OUT,
  input wire logic BLK_LAST_OUT,
  input wire logic READ_BUSY_OUT,
  input wire logic RAM_LOCKED_OUT
);
  timeunit 1ns;
  timeprecision 100ps;
  logic hs;
  logic [8:0] cnt;
  assign hs = BLK_VALID_OUT && BLK_READY_IN;
  // Byte index in the block, so offsets are checked without a data model
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      cnt <= 9'h000;
    end else if (hs) begin
      cnt <= BLK_LAST_OUT ? 9'h000 : cnt + 9'h001;
    end
  end
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  a_count_first_late: assert property (READ_REQ_IN && !READ_BUSY_OUT && !BLK_VALID_OUT
    |=> READ_BUSY_OUT ##1 BLK_VALID_OUT && BLK_DATA_OUT == 8'hFF) else $error("count late");
  a_count_byte: assert property (hs && cnt == 9'h000 |-> BLK_DATA_OUT == 8'hFF)
    else $error("bad count byte");
  a_last_flag: assert property (hs |-> BLK_LAST_OUT == (cnt == 9'h0FF))
    else $error("last misplaced");
  a_reserved_zero: assert property (hs && cnt >= 9'h0EF |-> BLK_DATA_OUT == 8'h00)
    else $error("reserved not zero");
  a_stall_hold: assert property (BLK_VALID_OUT && !BLK_READY_IN
    |=> BLK_VALID_OUT && $stable(BLK_DATA_OUT) && $stable(BLK_LAST_OUT)) else $error("stall");
  a_idle_quiet: assert property (!READ_BUSY_OUT && !BLK_VALID_OUT |=> !BLK_VALID_OUT)
    else $error("byte out of read");
  a_busy_cause: assert property ($rose(READ_BUSY_OUT) |-> $past(READ_REQ_IN))
    else $error("busy unasked");
  a_lock_set: assert property (LOCK_SET_IN |=> RAM_LOCKED_OUT) else $error("no lock");
  a_lock_hold: assert property (RAM_LOCKED_OUT && !READ_BUSY_OUT |=> RAM_LOCKED_OUT)
    else $error("lock lost");
  a_lock_clear: assert property ($fell(READ_BUSY_OUT) && !$past(LOCK_SET_IN)
    |-> !RAM_LOCKED_OUT) else $error("lock kept");
endmodule : flbf_checker

bind flbf_formatter flbf_checker flbf_checker_inst (.*);

// ===== flbf_sink.sv
module flbf_sink (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic stall_in,
  input wire logic valid_in,
  input wire logic [7:0] data_in,
  input wire logic last_in,
  output logic ready_out,
  output logic [7:0] ptr_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] got;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ready_out <= 1'b0;
      got <= 2'h0;
      ptr_out <= 8'h00;
    end else begin
      // A slow host accepts one byte in four on average
      ready_out <= stall_in ? ($urandom % 4 == 0) : 1'b1;
      if (valid_in && ready_out) begin
        got <= last_in ? 2'h0 : (got == 2'h2 ? got : got + 2'h1);
        if (got == 2'h1) ptr_out <= data_in;
      end
    end
  end
endmodule : flbf_sink

// ===== tb_flbf_formatter.sv
module tb_flbf_formatter;
  import flbf_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic REF_CLK_IN = 1'b0;
  logic RESETN_IN = 1'b0;
  logic CONV_DONE_IN = 1'b0;
  logic LOCK_SET_IN = 1'b0;
  logic READ_REQ_IN = 1'b0;
  logic [7:0][15:0] CHAN_OUT_VOLT_IN = '0;
  logic [15:0] VIN_VOLT_IN = '0;
  logic [15:0] TEMP_IN = '0;
  logic [7:0][7:0] STATUS_VOUT_IN = '0;
  logic [7:0][7:0] STATUS_MFR_IN = '0;
  logic [7:0][15:0] STATUS_WORD2_IN = '0;
  logic [7:0] STATUS_VIN_IN = '0;
  logic [7:0] STATUS_TEMP_IN = '0;
  logic [7:0][15:0] CHAN_OUT_VOLT_PEAK_IN = '0;
  logic [7:0][15:0] CHAN_OUT_VOLT_MINIMUM_IN = '0;
  logic [15:0] VIN_PEAK_IN = '0;
  logic [15:0] VIN_MINIMUM_IN = '0;
  logic [15:0] TEMP_PEAK_IN = '0;
  logic [15:0] TEMP_MINIMUM_IN = '0;
  logic [40:0] SHARED_TIME_IN = '0;
  logic BLK_READY_IN, BLK_VALID_OUT, BLK_LAST_OUT, READ_BUSY_OUT, RAM_LOCKED_OUT;
  logic [7:0] BLK_DATA_OUT, ptr;
  logic stall = 1'b0;
  logic [7:0] hist [166];
  logic [7:0] pre [72];
  int n, failures, n_tests;
  bit ok, locked;
  always #25 REF_CLK_IN = ~REF_CLK_IN;
  flbf_formatter flbf_formatter_inst (.*);
  flbf_sink flbf_sink_inst (.clk_in(REF_CLK_IN), .resetn_in(RESETN_IN), .stall_in(stall),
    .valid_in(BLK_VALID_OUT), .data_in(BLK_DATA_OUT), .last_in(BLK_LAST_OUT),
    .ready_out(BLK_READY_IN), .ptr_out(ptr));
  task final_report;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  function logic [7:0] pl();
    return n == 0 ? 8'h00 : 8'((n - 1) % 46);
  endfunction : pl
  function logic [7:0] lb(input int p);
    int c, k;
    if (p == 10 || p == 11) return VIN_VOLT_IN[8 * (p - 10) +: 8];
    if (p == 12) return STATUS_VIN_IN;
    if (p == 23 || p == 24) return TEMP_IN[8 * (p - 23) +: 8];
    if (p == 25) return STATUS_TEMP_IN;
    c = p < 10 ? p / 5 : p < 23 ? (p - 13) / 5 + 2 : (p - 26) / 5 + 4;
    k = p < 10 ? p % 5 : p < 23 ? (p - 13) % 5 : (p - 26) % 5;
    if (k < 2) return CHAN_OUT_VOLT_IN[c][8 * k +: 8];
    return k == 2 ? STATUS_VOUT_IN[c] : k == 3 ? STATUS_MFR_IN[c] : STATUS_WORD2_IN[c][7:0];
  endfunction : lb
  function logic [7:0] pb(input int i);
    int g, c, w;
    logic [15:0] v;
    logic [40:0] s;
    s = SHARED_TIME_IN >> (8 * (i - 2));
    if (i < 8) return s[7:0];
    g = (i - 8) / 4;
    w = i < 48 ? (i - 8) % 4 : (i - 48) % 3;
    c = g < 2 ? g : g < 5 ? g - 1 : g - 2;
    v = w < 2 ? CHAN_OUT_VOLT_PEAK_IN[c] : CHAN_OUT_VOLT_MINIMUM_IN[c];
    if (g == 2) v = w < 2 ? VIN_PEAK_IN : VIN_MINIMUM_IN;
    if (g == 5) v = w < 2 ? TEMP_PEAK_IN : TEMP_MINIMUM_IN;
    if (i < 48) return v[8 * (w % 2) +: 8];
    c = (i - 48) / 3;
    return w == 0 ? STATUS_VOUT_IN[c] : w == 1 ? STATUS_MFR_IN[c] : STATUS_WORD2_IN[c][7:0];
  endfunction : pb
  function logic [8:0] ex(input int x);
    int t;
    t = x - 1;
    if (x == 0) return 9'h1FF;
    if (t == 0) return {1'b1, pl()};
    if (t == 1) return {1'b1, n > 165 ? 8'hFF : 8'(n)};
    if (t < 72) return {ok, pre[t]};
    if (t > 237) return 9'h100;
    t = t - 72;
    return {t < n && t < 166, hist[(n - 1 - t) % 166]};
  endfunction : ex
  task rnd;
    CHAN_OUT_VOLT_IN <= {$urandom, $urandom, $urandom, $urandom};
    VIN_VOLT_IN <= 16'($urandom);
    TEMP_IN <= 16'($urandom);
    STATUS_VOUT_IN <= {$urandom, $urandom};
    STATUS_MFR_IN <= {$urandom, $urandom};
    STATUS_WORD2_IN <= {$urandom, $urandom, $urandom, $urandom};
    STATUS_VIN_IN <= 8'($urandom);
    STATUS_TEMP_IN <= 8'($urandom);
    CHAN_OUT_VOLT_PEAK_IN <= {$urandom, $urandom, $urandom, $urandom};
    CHAN_OUT_VOLT_MINIMUM_IN <= {$urandom, $urandom, $urandom, $urandom};
    VIN_PEAK_IN <= 16'($urandom);
    VIN_MINIMUM_IN <= 16'($urandom);
    TEMP_PEAK_IN <= 16'($urandom);
    TEMP_MINIMUM_IN <= 16'($urandom);
    SHARED_TIME_IN <= 41'({$urandom, $urandom});
  endtask : rnd
  task upd;
    int i;
    if (!locked) begin
      hist[n % 166] = lb(n % 46);
      for (i = 2; i < 72; i++) pre[i] = pb(i);
      n++;
      ok = 1'b1;
    end
  endtask : upd
  task conv(input int k);
    repeat (k) begin
      @(posedge REF_CLK_IN);
      rnd();
      CONV_DONE_IN <= 1'b1;
      #1;
      upd();
    end
    @(posedge REF_CLK_IN);
    CONV_DONE_IN <= 1'b0;
    // Inputs move on after the last conversion; the block must show the snapshot
    rnd();
  endtask : conv
  task rd(input logic slow, input logic cv);
    int x, w;
    logic [8:0] e;
    @(posedge REF_CLK_IN);
    stall <= slow;
    READ_REQ_IN <= 1'b1;
    // A conversion on the request edge must land in the block being read
    if (cv) begin
      rnd();
      CONV_DONE_IN <= 1'b1;
      #1;
      upd();
    end
    @(posedge REF_CLK_IN);
    READ_REQ_IN <= 1'b0;
    CONV_DONE_IN <= 1'b0;
    x = 0;
    for (w = 0; w < 5000 && x < 256; w++) begin
      @(posedge REF_CLK_IN);
      // Conversions and new requests during a read are both dropped
      CONV_DONE_IN <= x < 200 && $urandom % 2;
      READ_REQ_IN <= x > 2 && x < 200 && $urandom % 2;
      @(negedge REF_CLK_IN);
      if (BLK_VALID_OUT && BLK_READY_IN) begin
        e = ex(x);
        if (e[8]) chk("byte", BLK_DATA_OUT, e[7:0]);
        chk("last", {7'h00, BLK_LAST_OUT}, {7'h00, x == 255});
        x++;
      end
    end
    if (x < 256) begin
      failures++;
      final_report();
    end
    repeat (3) @(negedge REF_CLK_IN);
    locked = 1'b0;
    chk("pointer", ptr, pl());
    chk("lock", {7'h00, RAM_LOCKED_OUT}, 8'h00);
    chk("busy", {7'h00, READ_BUSY_OUT}, 8'h00);
  endtask : rd
  initial begin
    void'($urandom(32'hDF80));
    repeat (2) @(posedge REF_CLK_IN);
    RESETN_IN <= 1'b1;
    rd(1'b0, 1'b0);
    conv(50);
    rd(1'b0, 1'b0);
    conv(200 + $urandom % 40);
    rd(1'b1, 1'b0);
    @(posedge REF_CLK_IN);
    LOCK_SET_IN <= 1'b1;
    @(posedge REF_CLK_IN);
    LOCK_SET_IN <= 1'b0;
    locked = 1'b1;
    @(negedge REF_CLK_IN);
    chk("lock set", {7'h00, RAM_LOCKED_OUT}, 8'h01);
    conv(10);
    rd(1'b1, 1'b0);
    conv(1 + $urandom % 45);
    rd(1'b0, 1'b1);
    conv(20);
    @(posedge REF_CLK_IN);
    RESETN_IN <= 1'b0;
    n = 0;
    ok = 1'b0;
    repeat (2) @(posedge REF_CLK_IN);
    RESETN_IN <= 1'b1;
    rd(1'b1, 1'b0);
    final_report();
  end
endmodule : tb_flbf_formatter
